/* ado_pkg.sv */
// constants, types and register map of the sample output port
package ado_pkg;
  localparam int CODE_W = 12;
  localparam int LANES = CODE_W / 2;
  localparam int IN_W = 14;
  // seven whole cycles in the pipe plus the half cycle to the launching edge
  localparam int PIPE_DEPTH = 8;
  localparam logic signed [IN_W-1:0] CLIP_HI = 14'sh07FF;
  localparam logic signed [IN_W-1:0] CLIP_LO = 14'sh3800;
  localparam logic [CODE_W-1:0] CODE_MSB = 12'h800;
  localparam logic [CODE_W-1:0] OB_NFS = 12'h000;
  localparam logic [CODE_W-1:0] OB_MID = 12'h800;
  localparam logic [CODE_W-1:0] OB_PFS = 12'hFFF;
  localparam logic [CODE_W-1:0] TC_NFS = 12'h800;
  localparam logic [CODE_W-1:0] TC_PFS = 12'h7FF;
  localparam int CLK_MHZ = 200;
  localparam int PD_EXIT_US = 3000;
  localparam int SLEEP_EXIT_US = 300;
  localparam int MIN_RATE_KHZ = 5000;
  localparam int MIN_PER_CYC = CLK_MHZ * 1000 / MIN_RATE_KHZ;
  localparam int WAKE_W = 20;
  localparam int PER_W = 8;
  localparam logic [1:0] PSEL_ON = 2'h0;
  localparam logic [1:0] PSEL_MID = 2'h1;
  localparam int FSEL_2C_BIT = 0;
  localparam int FSEL_DIFF_BIT = 1;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAKE = 4'h2,
    ST_SLEEP = 4'h4,
    ST_DOWN = 4'h8
  } ado_state_t;

  typedef struct packed {
    logic vld;
    logic overrange_flag;
    logic [CODE_W-1:0] code;
  } ado_word_t;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;
  localparam int EV_W = 3;
  localparam int EV_OVR = 0;
  localparam int EV_SLOW = 1;
  localparam int EV_WAKE = 2;
  localparam int ST_FMT_BIT = 4;
  localparam int ST_DIFF_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } ado_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ado_axi_rsp_t;
endpackage

/* ado_dly.sv */
// delay line that carries sample words through the conversion pipeline
`timescale 1ns/100ps
module ado_dly #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // shift control
  input wire logic i_en,
  input wire logic i_flush,
  input wire logic [WIDTH-1:0] i_data,
  // oldest word
  output logic [WIDTH-1:0] o_data
);
  import ado_pkg::*;

  logic [WIDTH-1:0] stage [DEPTH];
  logic [WIDTH-1:0] next_stage [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_st
      logic [WIDTH-1:0] src;
      if (g == 0) begin : g_in
        assign src = i_data;
      end else begin : g_sh
        assign src = stage[g-1];
      end
      always_comb begin
        next_stage[g] = stage[g];
        if (i_flush) begin
          next_stage[g] = '0;
        end else if (i_en) begin
          next_stage[g] = src;
        end
      end
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stage[g] <= '0;
        end else begin
          stage[g] <= next_stage[g];
        end
      end
    end
  endgenerate

  assign o_data = stage[DEPTH-1];
endmodule

/* ado_top.sv */
// sampling converter digital core with ddr sample port and register slave
// Overview of operation
// - every sample becomes a 12-bit code.
// - the input is tracked while the conversion clock is high and frozen at its falling edge.
// - a sample's code is launched at a strobe falling edge 7.5 conversion cycles after sampling.
// - the output strobe toggles at the conversion clock rate, one period per sample.
// - conversion clocks from the lower limit up to the rated maximum are accepted.
// - offset binary runs from all zeros through 800 hex at mid-scale to all ones.
// - two's complement is offset binary with the top bit inverted.
// - inputs beyond full scale clip the code at the matching full-scale value.
// - a high power select pin powers everything down but the reference.
// - a mid-level power select pin puts the core to sleep.
// - wake-up from sleep is quicker than from power-down.
// - in power-down or sleep the outputs carry no data and the pipeline is lost.
// - the overrange flag is high for any sample beyond the 12-bit range.
// - the two extra output pairs are always low.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module ado_top #(
  parameter int PD_EXIT_CYC = ado_pkg::PD_EXIT_US * ado_pkg::CLK_MHZ,
  parameter int SLEEP_EXIT_CYC = ado_pkg::SLEEP_EXIT_US * ado_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // converter pins
  input wire logic i_conv_clk,
  input wire logic [ado_pkg::IN_W-1:0] i_analog,
  input wire logic [1:0] i_power_state_select,
  input wire logic [1:0] i_clock_and_format_select,
  // sample output port
  output logic o_output_strobe,
  output logic [ado_pkg::LANES-1:0] o_sample_code_bits,
  output logic o_overrange_flag,
  output logic [1:0] o_constant_low_pair,
  output logic o_diff_clock_mode,
  // register bus and interrupt
  input wire ado_pkg::ado_axi_req_t i_axi,
  output ado_pkg::ado_axi_rsp_t o_axi,
  output logic o_irq
);
  import ado_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  localparam int PIN_W = 1 + IN_W + 4;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {i_conv_clk, i_analog, i_power_state_select, i_clock_and_format_select};
      pin_s2 <= pin_s1;
    end
  end

  logic conv_lvl;
  logic signed [IN_W-1:0] ain;
  logic [1:0] psel;
  logic [1:0] fsel;
  logic fmt_2c;
  assign conv_lvl = pin_s2[PIN_W-1];
  assign ain = signed'(pin_s2[PIN_W-2 -: IN_W]);
  assign psel = pin_s2[3:2];
  assign fsel = pin_s2[1:0];
  assign fmt_2c = fsel[FSEL_2C_BIT];

  // conversion clock edges
  logic conv_q;
  logic fall;
  logic rise;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= conv_lvl;
    end
  end
  assign fall = conv_q & ~conv_lvl;
  assign rise = ~conv_q & conv_lvl;

  // code of the sample held at this falling edge
  ado_word_t cur_word;
  logic [CODE_W-1:0] clip;
  logic [CODE_W-1:0] ob;
  always_comb begin
    clip = ain[CODE_W-1:0];
    if (ain > CLIP_HI) begin
      clip = CLIP_HI[CODE_W-1:0];
    end else if (ain < CLIP_LO) begin
      clip = CLIP_LO[CODE_W-1:0];
    end
    ob = clip ^ CODE_MSB;
    cur_word.vld = 1'b1;
    cur_word.overrange_flag = (ain > CLIP_HI) || (ain < CLIP_LO);
    cur_word.code = fmt_2c ? (ob ^ CODE_MSB) : ob;
  end

  mid_scale_a: assert property (ain == '0 |-> cur_word.code == (fmt_2c ? '0 : OB_MID))
    else $error("mid-scale code wrong");
  clip_high_a: assert property (ain > CLIP_HI |-> cur_word.overrange_flag && cur_word.code == (fmt_2c ? TC_PFS : OB_PFS))
    else $error("positive clip wrong");
  clip_low_a: assert property (ain < CLIP_LO |-> cur_word.overrange_flag && cur_word.code == (fmt_2c ? TC_NFS : OB_NFS))
    else $error("negative clip wrong");

  // power state machine
  ado_state_t state;
  ado_state_t next_state;
  logic [WAKE_W-1:0] wake_cnt;
  logic [WAKE_W-1:0] next_wake_cnt;
  logic wake_done;
  logic running;
  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    wake_done = 1'b0;
    if (psel == PSEL_MID) begin
      next_state = ST_SLEEP;
    end else if (psel != PSEL_ON) begin
      next_state = ST_DOWN;
    end else begin
      case (state)
        ST_SLEEP: begin
          next_state = ST_WAKE;
          next_wake_cnt = WAKE_W'(SLEEP_EXIT_CYC - 1);
        end
        ST_DOWN: begin
          next_state = ST_WAKE;
          next_wake_cnt = WAKE_W'(PD_EXIT_CYC - 1);
        end
        ST_WAKE: begin
          if (wake_cnt == '0) begin
            next_state = ST_RUN;
            wake_done = 1'b1;
          end else begin
            next_wake_cnt = wake_cnt - 1'b1;
          end
        end
        ST_RUN: next_state = ST_RUN;
        default: next_state = ST_DOWN;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_DOWN;
      wake_cnt <= '0;
    end else begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
    end
  end
  assign running = (state == ST_RUN);

  power_down_a: assert property (psel[1] |=> state == ST_DOWN)
    else $error("power-down not entered");
  sleep_entry_a: assert property (psel == PSEL_MID |=> state == ST_SLEEP)
    else $error("sleep not entered");
  wake_load_a: assert property (state == ST_SLEEP && psel == PSEL_ON
      |=> state == ST_WAKE && wake_cnt == WAKE_W'(SLEEP_EXIT_CYC - 1) && SLEEP_EXIT_CYC < PD_EXIT_CYC)
    else $error("sleep exit time wrong");

  // conversion pipeline, flushed whenever the core is not converting
  ado_word_t pipe_out;
  ado_dly #(
    .WIDTH($bits(ado_word_t)),
    .DEPTH(PIPE_DEPTH)
  ) u_pipe (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(fall && running),
    .i_flush(!running),
    .i_data(cur_word),
    .o_data(pipe_out)
  );

  // ddr output stage: odd bits after the strobe falls, even bits after it rises
  logic strobe;
  logic launch;
  logic even_half;
  ado_word_t out_word;
  logic [LANES-1:0] lanes;
  logic ovr_out;
  logic diff_mode;
  logic next_strobe;
  logic next_launch;
  logic next_even;
  ado_word_t next_out_word;
  logic [LANES-1:0] next_lanes;
  logic next_ovr;
  logic [LANES-1:0] odd_bits;
  logic [LANES-1:0] even_bits;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign odd_bits[g] = pipe_out.code[2*g+1];
      assign even_bits[g] = out_word.code[2*g];
    end
  endgenerate

  always_comb begin
    next_strobe = ~conv_lvl;
    next_launch = rise;
    next_even = fall;
    next_out_word = out_word;
    next_lanes = lanes;
    next_ovr = ovr_out;
    if (!running) begin
      next_out_word = '0;
      next_lanes = '0;
      next_ovr = 1'b0;
    end else if (launch) begin
      next_out_word = pipe_out;
      next_lanes = pipe_out.vld ? odd_bits : '0;
      next_ovr = pipe_out.vld & pipe_out.overrange_flag;
    end else if (even_half) begin
      next_lanes = out_word.vld ? even_bits : '0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strobe <= 1'b0;
      launch <= 1'b0;
      even_half <= 1'b0;
      out_word <= '0;
      lanes <= '0;
      ovr_out <= 1'b0;
      diff_mode <= 1'b0;
      o_constant_low_pair <= 2'h0;
    end else begin
      strobe <= next_strobe;
      launch <= next_launch;
      even_half <= next_even;
      out_word <= next_out_word;
      lanes <= next_lanes;
      ovr_out <= next_ovr;
      diff_mode <= fsel[FSEL_DIFF_BIT];
      o_constant_low_pair <= 2'h0;
    end
  end
  assign o_output_strobe = strobe;
  assign o_sample_code_bits = lanes;
  assign o_overrange_flag = ovr_out;
  assign o_diff_clock_mode = diff_mode;

  // falls seen since the core last started converting
  logic [3:0] fall_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fall_cnt <= '0;
    end else if (!running) begin
      fall_cnt <= '0;
    end else if (fall && fall_cnt < 4'(PIPE_DEPTH)) begin
      fall_cnt <= fall_cnt + 1'b1;
    end
  end

  strobe_rate_a: assert property ($rose(conv_lvl) |=> $fell(strobe) ##1 !strobe)
    else $error("strobe does not follow conversion clock");
  latency_a: assert property (launch && running |-> pipe_out.vld == (fall_cnt >= 4'(PIPE_DEPTH)))
    else $error("pipeline latency wrong");
  odd_launch_a: assert property (launch && running && pipe_out.vld |=> lanes == $past(odd_bits)
      && ovr_out == $past(pipe_out.overrange_flag))
    else $error("launched word wrong");
  quiet_out_a: assert property (!running |=> lanes == '0 && !ovr_out)
    else $error("outputs active while not converting");
  const_low_a: assert property (o_constant_low_pair == 2'h0)
    else $error("constant pair not low");

  // conversion clock slower than the lowest rate
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] next_per_cnt;
  logic slow_ev;
  always_comb begin
    next_per_cnt = per_cnt;
    slow_ev = running && !fall && per_cnt == PER_W'(MIN_PER_CYC);
    if (!running || fall) begin
      next_per_cnt = '0;
    end else if (per_cnt <= PER_W'(MIN_PER_CYC)) begin
      next_per_cnt = per_cnt + 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= next_per_cnt;
    end
  end

  // axi4-lite slave, status, mask and interrupt
  ado_axi_rsp_t axi;
  ado_axi_rsp_t next_axi;
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] wdata_q;
  logic [31:0] next_wdata;
  logic wstrb0;
  logic next_wstrb0;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] next_mask;
  logic [EV_W-1:0] clr;
  logic [EV_W-1:0] events;
  logic irq;
  logic next_irq;

  always_comb begin
    next_axi = axi;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_wdata = wdata_q;
    next_wstrb0 = wstrb0;
    next_mask = mask;
    clr = '0;
    events = '0;
    events[EV_OVR] = fall && running && cur_word.overrange_flag;
    events[EV_SLOW] = slow_ev;
    events[EV_WAKE] = wake_done;
    if (i_axi.awvalid && axi.awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && axi.wready) begin
      next_w_held = 1'b1;
      next_wdata = i_axi.wdata;
      next_wstrb0 = i_axi.wstrb[0];
    end
    if (axi.bvalid && i_axi.bready) begin
      next_axi.bvalid = 1'b0;
    end
    if (aw_held && w_held && !axi.bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_axi.bvalid = 1'b1;
      next_axi.bresp = RESP_OKAY;
      if (aw_addr == REG_MASK) begin
        if (wstrb0) begin
          next_mask = wdata_q[EV_W-1:0];
        end
      end else if (aw_addr != REG_STATUS && aw_addr != REG_STATE) begin
        next_axi.bresp = RESP_SLVERR;
      end
    end
    next_axi.awready = !next_aw_held;
    next_axi.wready = !next_w_held;
    if (axi.rvalid && i_axi.rready) begin
      next_axi.rvalid = 1'b0;
    end
    if (i_axi.arvalid && axi.arready) begin
      next_axi.rvalid = 1'b1;
      next_axi.rresp = RESP_OKAY;
      next_axi.rdata = '0;
      case (i_axi.araddr)
        REG_STATUS: begin
          next_axi.rdata[EV_W-1:0] = status;
          clr = status;
        end
        REG_MASK: next_axi.rdata[EV_W-1:0] = mask;
        REG_STATE: begin
          next_axi.rdata[$bits(ado_state_t)-1:0] = state;
          next_axi.rdata[ST_FMT_BIT] = fmt_2c;
          next_axi.rdata[ST_DIFF_BIT] = diff_mode;
        end
        default: next_axi.rresp = RESP_SLVERR;
      endcase
    end
    next_axi.arready = !next_axi.rvalid;
    // an event in the clearing cycle stays set
    next_status = (status & ~clr) | events;
    next_irq = |(next_status & next_mask);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      axi <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      wdata_q <= '0;
      wstrb0 <= 1'b0;
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      axi <= next_axi;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      wdata_q <= next_wdata;
      wstrb0 <= next_wstrb0;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end
  assign o_axi = axi;
  assign o_irq = irq;

  slow_clock_a: assert property (slow_ev |=> status[EV_SLOW])
    else $error("slow clock not flagged");
endmodule

/* ado_rx_model.sv */
// receiving logic that captures the ddr sample port into whole words
`timescale 1ns/100ps
module ado_rx_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // capture control and sample port
  input wire logic i_enable,
  input wire logic i_strobe,
  input wire logic [ado_pkg::LANES-1:0] i_lanes,
  input wire logic i_ovr,
  // captured word, vld pulses once per word
  output ado_pkg::ado_word_t o_word
);
  import ado_pkg::*;
  logic strobe_q, armed;
  logic [LANES-1:0] odd;
  int skip;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strobe_q <= 1'b0;
      armed <= 1'b0;
      odd <= '0;
      skip <= 8;
      o_word <= '0;
    end else begin
      strobe_q <= i_strobe;
      o_word.vld <= 1'b0;
      if (!i_enable) begin
        armed <= 1'b0;
        skip <= 8;
      end else if (i_strobe && !strobe_q) begin
        odd <= i_lanes;
        armed <= 1'b1;
      end else if (!i_strobe && strobe_q && armed) begin
        if (skip > 0) begin
          skip <= skip - 1;
        end else begin
          o_word.vld <= 1'b1;
          o_word.overrange_flag <= i_ovr;
          for (int i = 0; i < LANES; i++) begin
            o_word.code[2*i+1] <= odd[i];
            o_word.code[2*i] <= i_lanes[i];
          end
        end
      end
    end
  end
endmodule

/* ado_top_tb_top.sv */
// self-checking bench for the sample output port and its register slave
`timescale 1ns/100ps
module ado_top_tb_top;
  import ado_pkg::*;
  localparam int PD_CYC = 20;
  localparam int SL_CYC = 5;
  localparam logic [IN_W-1:0] EDGE_V [8] = '{14'h3800, 14'h07FF, 14'h0000, 14'h0800, 14'h37FF, 14'h1FFF,
                                             14'h2000, 14'h0400};
  logic i_clk, i_rst_n, conv_clk, conv_run, strobe, overrange_flag, diff_mode, irq, model_en;
  logic signed [IN_W-1:0] ana;
  logic [1:0] psel, fsel, low_pair, resp;
  logic [LANES-1:0] lanes;
  logic [31:0] rd;
  ado_axi_req_t axi_req;
  ado_axi_rsp_t axi_rsp;
  ado_word_t rx_word;
  ado_word_t exp_q[$];
  int bad_count, n_tests, seed, t_pd, t_sl;

  ado_top #(.PD_EXIT_CYC(PD_CYC), .SLEEP_EXIT_CYC(SL_CYC)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv_clk(conv_clk), .i_analog(ana),
    .i_power_state_select(psel), .i_clock_and_format_select(fsel), .o_output_strobe(strobe),
    .o_sample_code_bits(lanes), .o_overrange_flag(overrange_flag), .o_constant_low_pair(low_pair),
    .o_diff_clock_mode(diff_mode), .i_axi(axi_req), .o_axi(axi_rsp), .o_irq(irq));
  ado_rx_model rx_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_enable(model_en), .i_strobe(strobe),
    .i_lanes(lanes), .i_ovr(overrange_flag), .o_word(rx_word));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // conversion clock runs free, 48 ns period, parked low when stopped
  initial begin
    conv_clk = 1'b0;
    #7;
    forever #24 conv_clk = conv_run ? ~conv_clk : 1'b0;
  end

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic timed_out(input string what);
    bad_count++;
    $display("Error %s expected answer seen timeout", what);
    stop_test();
  endtask
  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_word(input ado_word_t exp, input ado_word_t got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error sample word expected %h seen %h", exp, got);
    end
  endtask
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    logic aw_p, w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    while ((aw_p || w_p) && n < 50) begin
      @(posedge i_clk);
      n++;
      if (aw_p && axi_rsp.awready === 1'b1) begin
        aw_p = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (w_p && axi_rsp.wready === 1'b1) begin
        w_p = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge i_clk);
      n++;
    end while (axi_rsp.bvalid !== 1'b1 && n < 50);
    if (n >= 50) timed_out("write");
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (axi_rsp.arready !== 1'b1 && n < 50);
    axi_req.arvalid <= 1'b0;
    do begin
      @(posedge i_clk);
      n++;
    end while (axi_rsp.rvalid !== 1'b1 && n < 50);
    if (n >= 50) timed_out("read");
    rd = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
    @(posedge i_clk);
  endtask
  // in range the offset code is linear about mid-scale, beyond it the full-scale codes stand
  function automatic ado_word_t exp_of(input logic signed [IN_W-1:0] a, input logic tc);
    ado_word_t w;
    w.vld = 1'b1;
    w.overrange_flag = (a > CLIP_HI) || (a < CLIP_LO);
    w.code = OB_MID + a[CODE_W-1:0];
    if (a > CLIP_HI) w.code = tc ? TC_PFS : OB_PFS;
    else if (a < CLIP_LO) w.code = tc ? TC_NFS : OB_NFS;
    else if (tc) w.code = w.code ^ CODE_MSB;
    return w;
  endfunction
  // waits for the conversion clock to reach a level from the other one, on a bounded count
  task automatic conv_edge(input logic lvl);
    int n;
    n = 0;
    while (conv_clk === lvl && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    while (conv_clk !== lvl && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 40) timed_out("conversion clock");
  endtask
  task automatic wake_time(input logic [1:0] p, input logic [3:0] st, output int t);
    logic any;
    any = 1'b0;
    psel <= p;
    repeat (12) @(posedge i_clk);
    repeat (40) begin
      @(posedge i_clk);
      any = any | (|lanes) | overrange_flag | (|low_pair);
    end
    cmp_val("idle port", 0, any);
    axi_rd(REG_STATE);
    cmp_val("state", st, rd[3:0]);
    axi_rd(REG_STATUS);
    psel <= PSEL_ON;
    t = 0;
    while (irq !== 1'b1 && t < 500) begin
      @(posedge i_clk);
      t++;
    end
    if (t >= 500) timed_out("wake");
    axi_rd(REG_STATUS);
    cmp_val("wake flag", 32'h4, rd & 32'h4);
    repeat (2) @(posedge i_clk);
    cmp_val("irq clear", 0, irq);
  endtask
  // value tracked while the clock is high, scrambled after the falling edge
  task automatic run_stream(input logic tc);
    logic signed [IN_W-1:0] v;
    int n;
    conv_edge(1'b1);
    for (int i = 0; i < 24; i++) begin
      v = (i < 8) ? EDGE_V[i] : IN_W'($random(seed));
      @(posedge i_clk);
      model_en <= 1'b1;
      ana <= v ^ 14'h1555;
      repeat (2) @(posedge i_clk);
      ana <= v;
      exp_q.push_back(exp_of(v, tc));
      conv_edge(1'b0);
      repeat (3) @(posedge i_clk);
      ana <= ~v;
      conv_edge(1'b1);
    end
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 400) timed_out("sample words");
    model_en <= 1'b0;
  endtask

  always @(posedge i_clk) begin
    if (rx_word.vld === 1'b1) begin
      cmp_val("constant pair", 0, low_pair);
      if (exp_q.size() == 0) begin
        cmp_word('0, rx_word);
      end else begin
        cmp_word(exp_q.pop_front(), rx_word);
      end
    end
  end

  initial begin
    seed = 47;
    bad_count = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    conv_run = 1'b1;
    ana = '0;
    psel = PSEL_ON;
    fsel = 2'h0;
    axi_req = '0;
    model_en = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    axi_wr(REG_MASK, 32'h4);
    cmp_val("mask write resp", RESP_OKAY, resp);
    axi_rd(REG_MASK);
    cmp_val("mask", 32'h4, rd);
    axi_wr(4'hC, 32'hFFFFFFFF);
    cmp_val("unmapped write resp", RESP_SLVERR, resp);
    axi_rd(4'hC);
    cmp_val("unmapped read resp", RESP_SLVERR, resp);
    wake_time(2'h2, 4'h8, t_pd);
    wake_time(PSEL_MID, 4'h4, t_sl);
    cmp_val("wake gap", PD_CYC - SL_CYC, t_pd - t_sl);
    for (int f = 0; f < 4; f++) begin
      fsel <= f[1:0];
      axi_wr(REG_STATE, 32'h0);
      cmp_val("state write resp", RESP_OKAY, resp);
      repeat (200) @(posedge i_clk);
      axi_rd(REG_STATE);
      cmp_val("state", {26'h0, f[1:0], 4'h1}, rd);
      cmp_val("clock mode", f[1], diff_mode);
      run_stream(f[0]);
    end
    cmp_val("masked irq", 0, irq);
    axi_wr(REG_MASK, 32'h1);
    repeat (2) @(posedge i_clk);
    cmp_val("overrange irq", 1, irq);
    axi_rd(REG_STATUS);
    cmp_val("overrange flag", 32'h1, rd & 32'h1);
    conv_run <= 1'b0;
    axi_wr(REG_MASK, 32'h2);
    repeat (100) @(posedge i_clk);
    cmp_val("slow irq", 1, irq);
    axi_rd(REG_STATUS);
    cmp_val("slow flag", 32'h2, rd & 32'h2);
    stop_test();
  end
endmodule
